// ==== common/cei_pkg.sv ====
// constants for the clock event interrupt mask block
package cei_pkg;

	// register bus geometry
	localparam int CEI_ADR_W = 8;
	localparam int CEI_DAT_W = 32;
	localparam int CEI_SEL_W = 4;
	localparam int CEI_NSRC = 19;

	// register byte addresses
	localparam logic [7:0] CEI_ADR_MASK = 8'h00;
	localparam logic [7:0] CEI_ADR_STATUS = 8'h04;
	localparam logic [7:0] CEI_ADR_PEND = 8'h08;
	localparam logic [7:0] CEI_ADR_QUAL = 8'h0c;

	// source bit positions, shared by mask, status and event vectors
	localparam int CEI_REF1_MT = 0;
	localparam int CEI_REF1_LT = 1;
	localparam int CEI_REF0_ST = 2;
	localparam int CEI_REF0_MT = 3;
	localparam int CEI_REF0_LT = 4;
	localparam int CEI_LB_STATE = 5;
	localparam int CEI_LB_HOLD = 6;
	localparam int CEI_LB_UNLOCK = 7;
	localparam int CEI_RSVD = 8;
	localparam int CEI_LA_STATE = 9;
	localparam int CEI_LA_HOLD = 10;
	localparam int CEI_LA_UNLOCK = 11;
	localparam int CEI_SYS_STATE = 12;
	localparam int CEI_SYS_HOLD = 13;
	localparam int CEI_SYS_UNLOCK = 14;
	localparam int CEI_RF_UNLOCK = 15;
	localparam int CEI_AC_UNLOCK = 16;
	localparam int CEI_AB_UNLOCK = 17;
	localparam int CEI_AA_UNLOCK = 18;

	// field groups and reset values
	localparam logic [18:0] CEI_VALID_BITS = 19'h7feff;
	localparam logic [18:0] CEI_REF0_BITS = 19'h0001c;
	localparam logic [18:0] CEI_REF1_BITS = 19'h00003;
	localparam logic [18:0] CEI_MASK_RST = 19'h00000;
	localparam logic [18:0] CEI_STATUS_RST = 19'h00000;
	localparam logic [31:0] CEI_RD_ZERO = 32'h00000000;
	localparam int CEI_QUAL_W = 2;

endpackage : cei_pkg

// ==== design/cei_irq_mask.sv ====
// interrupt masking and event latching for clock monitor and loop events
//
// Functional notes
// [RULE1] second input mid-term mask set: failure neither interrupts nor disqualifies
// [RULE2] second input long-term mask set: failure neither interrupts nor disqualifies
// [RULE3] first input short-term mask set: failure neither interrupts nor disqualifies
// [RULE4] first input mid-term mask set: failure neither interrupts nor disqualifies
// [RULE5] first input long-term mask set: failure neither interrupts nor disqualifies
// [RULE6] mask zero enables the interrupt, one masks it
// [RULE7] second digital loop state-change interrupt suppressed while its mask is one
// [RULE8] second digital loop holdover interrupt suppressed while its mask is one
// [RULE9] second digital loop unlock interrupt suppressed while its mask is one
// [RULE10] first digital loop state-change interrupt suppressed while its mask is one
// [RULE11] first digital loop holdover interrupt suppressed while its mask is one
// [RULE12] first digital loop unlock interrupt suppressed while its mask is one
// [RULE13] system digital loop state-change interrupt suppressed while its mask is one
// [RULE14] system digital loop holdover interrupt suppressed while its mask is one
// [RULE15] system digital loop unlock interrupt suppressed while its mask is one
// [RULE16] rf synthesizer unlock interrupt suppressed while its mask is one
// [RULE17] third analog loop unlock interrupt suppressed while its mask is one
// [RULE18] second analog loop unlock interrupt suppressed while its mask is one
// [RULE19] first analog loop unlock interrupt suppressed while its mask is one
// [RULE20] software keeps the reserved mask bit at its default zero
// [RULE21] latched status bit clears on write of one, zero leaves it
// [RULE22] every event latches its status flag until software clears it
// [RULE23] interrupt high while any unmasked latched flag is set
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps

module cei_irq_mask
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [cei_pkg::CEI_ADR_W-1:0] i_wb_adr,
	input wire logic [cei_pkg::CEI_SEL_W-1:0] i_wb_sel,
	input wire logic [cei_pkg::CEI_DAT_W-1:0] i_wb_dat,
	output logic [cei_pkg::CEI_DAT_W-1:0] o_wb_dat,
	output logic o_wb_ack,
	// event sources, one bit per source
	input wire logic [cei_pkg::CEI_NSRC-1:0] i_src_event,
	// results
	output logic o_irq,
	output logic o_ref0_disq,
	output logic o_ref1_disq
);
	import cei_pkg::*;

	logic ack_ff;
	logic [CEI_DAT_W-1:0] rdat_ff;
	logic [CEI_NSRC-1:0] mask_ff;
	logic [CEI_NSRC-1:0] status_ff;
	logic irq_ff;
	logic ref0_disq_ff;
	logic ref1_disq_ff;

	logic [CEI_DAT_W-1:0] nxt_rdat;
	logic [CEI_NSRC-1:0] nxt_mask;
	logic [CEI_NSRC-1:0] nxt_status;
	logic nxt_irq;
	logic nxt_ref0_disq;
	logic nxt_ref1_disq;

	// byte enables widened to a bit mask
	function automatic logic [CEI_DAT_W-1:0] sel_bits(input logic [CEI_SEL_W-1:0] sel);
		logic [CEI_DAT_W-1:0] res;
		res = CEI_RD_ZERO;
		for (int b = 0; b < CEI_SEL_W; b++)
		begin
			res[b*8 +: 8] = {8{sel[b]}};
		end
		return res;
	endfunction : sel_bits

	wire logic bus_hit;
	wire logic bus_wr;
	wire logic wr_mask;
	wire logic wr_status;
	wire logic [CEI_DAT_W-1:0] wr_bits;
	wire logic [CEI_NSRC-1:0] be_bits;
	wire logic [CEI_NSRC-1:0] clr_bits;
	wire logic [CEI_NSRC-1:0] pend_bits;
	wire logic [CEI_NSRC-1:0] live_fail;

	// one access per ack; second beat of a held request is not retaken
	assign bus_hit = i_wb_cyc & i_wb_stb & ~ack_ff;
	assign bus_wr = bus_hit & i_wb_we;
	assign wr_mask = bus_wr & (i_wb_adr == CEI_ADR_MASK);
	assign wr_status = bus_wr & (i_wb_adr == CEI_ADR_STATUS);
	assign wr_bits = sel_bits(i_wb_sel);
	assign be_bits = wr_bits[CEI_NSRC-1:0];

	// [RULE21] write one clears
	assign clr_bits = wr_status ? (i_wb_dat[CEI_NSRC-1:0] & be_bits) : CEI_STATUS_RST;

	// [RULE6] zero enables, one masks
	assign pend_bits = status_ff & ~mask_ff & CEI_VALID_BITS;
	assign live_fail = i_src_event & ~mask_ff;

	// mask register keeps the reserved bit too; it drives nothing
	assign nxt_mask = wr_mask ? ((mask_ff & ~be_bits) | (i_wb_dat[CEI_NSRC-1:0] & be_bits)) : mask_ff;

	// [RULE22] latch events; set beats a clear in the same cycle
	assign nxt_status = ((status_ff & ~clr_bits) | i_src_event) & CEI_VALID_BITS;

	// [RULE7] [RULE8] [RULE9] [RULE10] [RULE11] [RULE12] [RULE13] masked loop events gated
	// [RULE14] [RULE15] [RULE16] [RULE17] [RULE18] [RULE19] masked holdover and unlock events gated
	// [RULE23] irq follows unmasked latched flags
	assign nxt_irq = |(nxt_status & ~nxt_mask & CEI_VALID_BITS);

	// [RULE4] [RULE5] [RULE3] masked failures do not disqualify first input
	assign nxt_ref0_disq = |(live_fail & CEI_REF0_BITS);

	// [RULE1] [RULE2] masked failures do not disqualify second input
	assign nxt_ref1_disq = |(live_fail & CEI_REF1_BITS);

	// read decode; unmapped addresses answer zero
	always_comb
	begin
		nxt_rdat = CEI_RD_ZERO;
		if (!bus_hit || i_wb_we)
		begin
			nxt_rdat = CEI_RD_ZERO;
		end
		else if (i_wb_adr == CEI_ADR_MASK)
		begin
			nxt_rdat[CEI_NSRC-1:0] = mask_ff;
		end
		else if (i_wb_adr == CEI_ADR_STATUS)
		begin
			nxt_rdat[CEI_NSRC-1:0] = status_ff;
		end
		else if (i_wb_adr == CEI_ADR_PEND)
		begin
			nxt_rdat[CEI_NSRC-1:0] = pend_bits;
		end
		else if (i_wb_adr == CEI_ADR_QUAL)
		begin
			nxt_rdat[CEI_QUAL_W-1:0] = {ref1_disq_ff, ref0_disq_ff};
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			ack_ff <= 1'b0;
			rdat_ff <= CEI_RD_ZERO;
		end
		else
		begin
			ack_ff <= bus_hit;
			rdat_ff <= nxt_rdat;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			mask_ff <= CEI_MASK_RST;
			status_ff <= CEI_STATUS_RST;
		end
		else
		begin
			mask_ff <= nxt_mask;
			status_ff <= nxt_status;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			irq_ff <= 1'b0;
			ref0_disq_ff <= 1'b0;
			ref1_disq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= nxt_irq;
			ref0_disq_ff <= nxt_ref0_disq;
			ref1_disq_ff <= nxt_ref1_disq;
		end
	end

	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdat_ff;
	assign o_irq = irq_ff;
	assign o_ref0_disq = ref0_disq_ff;
	assign o_ref1_disq = ref1_disq_ff;

	// masked single fault on second input mid-term leaves it qualified
	chk_r1_mt_mask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE1]
		(mask_ff[CEI_REF1_MT] && live_fail[CEI_REF1_LT] == 1'b0)
		|=> !o_ref1_disq)
		else $error("masked mid-term fault disqualified second input");

	chk_r1_lt_mask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE2]
		(mask_ff[CEI_REF1_LT] && live_fail[CEI_REF1_MT] == 1'b0)
		|=> !o_ref1_disq)
		else $error("masked long-term fault disqualified second input");

	chk_r0_st_mask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE3]
		(mask_ff[CEI_REF0_ST] && !live_fail[CEI_REF0_MT] && !live_fail[CEI_REF0_LT])
		|=> !o_ref0_disq)
		else $error("masked short-term fault disqualified first input");

	chk_r0_mt_mask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE4]
		(mask_ff[CEI_REF0_MT] && !live_fail[CEI_REF0_ST] && !live_fail[CEI_REF0_LT])
		|=> !o_ref0_disq)
		else $error("masked mid-term fault disqualified first input");

	chk_r0_lt_mask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE5]
		(mask_ff[CEI_REF0_LT] && !live_fail[CEI_REF0_ST] && !live_fail[CEI_REF0_MT])
		|=> !o_ref0_disq)
		else $error("masked long-term fault disqualified first input");

	chk_unmask_fires: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE6]
		((|(i_src_event & ~mask_ff & CEI_VALID_BITS)) && !wr_mask)
		|=> o_irq)
		else $error("unmasked event did not raise interrupt");

	chk_unmask_disq: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE6]
		(i_src_event[CEI_REF1_MT] && !mask_ff[CEI_REF1_MT]) |=> o_ref1_disq)
		else $error("unmasked failure did not disqualify second input");

	chk_lb_state: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE7]
		(mask_ff[CEI_LB_STATE] && pend_bits == 19'h00000) |-> !o_irq)
		else $error("masked second loop state change interrupted");

	chk_lb_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE8]
		(status_ff[CEI_LB_HOLD] && mask_ff[CEI_LB_HOLD] && !(|pend_bits)) |-> !o_irq)
		else $error("masked second loop holdover interrupted");

	chk_lb_unlock: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE9]
		(status_ff[CEI_LB_UNLOCK] && mask_ff[CEI_LB_UNLOCK] && !(|pend_bits)) |-> !o_irq)
		else $error("masked second loop unlock interrupted");

	chk_la_state: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE10]
		(status_ff[CEI_LA_STATE] && mask_ff[CEI_LA_STATE] && !(|pend_bits)) |-> !o_irq)
		else $error("masked first loop state change interrupted");

	chk_la_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE11]
		(status_ff[CEI_LA_HOLD] && mask_ff[CEI_LA_HOLD] && !(|pend_bits)) |-> !o_irq)
		else $error("masked first loop holdover interrupted");

	chk_la_unlock: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE12]
		(status_ff[CEI_LA_UNLOCK] && mask_ff[CEI_LA_UNLOCK] && !(|pend_bits)) |-> !o_irq)
		else $error("masked first loop unlock interrupted");

	chk_sys_state: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE13]
		(status_ff[CEI_SYS_STATE] && mask_ff[CEI_SYS_STATE] && !(|pend_bits)) |-> !o_irq)
		else $error("masked system loop state change interrupted");

	chk_sys_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE14]
		(status_ff[CEI_SYS_HOLD] && mask_ff[CEI_SYS_HOLD] && !(|pend_bits)) |-> !o_irq)
		else $error("masked system loop holdover interrupted");

	chk_sys_unlock: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE15]
		(status_ff[CEI_SYS_UNLOCK] && mask_ff[CEI_SYS_UNLOCK] && !(|pend_bits)) |-> !o_irq)
		else $error("masked system loop unlock interrupted");

	chk_rf_unlock: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE16]
		(status_ff[CEI_RF_UNLOCK] && mask_ff[CEI_RF_UNLOCK] && !(|pend_bits)) |-> !o_irq)
		else $error("masked rf synthesizer unlock interrupted");

	chk_ac_unlock: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE17]
		(status_ff[CEI_AC_UNLOCK] && mask_ff[CEI_AC_UNLOCK] && !(|pend_bits)) |-> !o_irq)
		else $error("masked third analog loop unlock interrupted");

	chk_ab_unlock: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE18]
		(status_ff[CEI_AB_UNLOCK] && mask_ff[CEI_AB_UNLOCK] && !(|pend_bits)) |-> !o_irq)
		else $error("masked second analog loop unlock interrupted");

	chk_aa_unlock: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE19]
		(status_ff[CEI_AA_UNLOCK] && mask_ff[CEI_AA_UNLOCK] && !(|pend_bits)) |-> !o_irq)
		else $error("masked first analog loop unlock interrupted");

	chk_w1c_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE21]
		(wr_status && !(|i_src_event)) |=> ((status_ff & $past(clr_bits)) == 19'h00000))
		else $error("write of one did not clear status");

	chk_w1c_keep: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE21]
		wr_status |=> ((status_ff & ~$past(clr_bits)) ==
		(($past(status_ff) | $past(i_src_event)) & ~$past(clr_bits) & CEI_VALID_BITS)))
		else $error("write of zero changed status");

	chk_flag_latch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE22]
		(i_src_event[CEI_RF_UNLOCK] ##1 !wr_status [*2]) |=> status_ff[CEI_RF_UNLOCK])
		else $error("unlock flag not held until cleared");

	chk_irq_level: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE23]
		(|pend_bits) == o_irq)
		else $error("interrupt does not match unmasked flags");

	chk_irq_drop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE23]
		(o_irq && wr_status && !(|i_src_event) && ((pend_bits & ~clr_bits) == 19'h00000) && !wr_mask)
		|=> !o_irq)
		else $error("interrupt stayed after last flag cleared");

	// unmasked failures must disqualify their input one cycle later
	chk_r1_mt_live: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE1]
		(i_src_event[CEI_REF1_MT] && !mask_ff[CEI_REF1_MT]) |=> o_ref1_disq)
		else $error("unmasked mid-term fault kept second input qualified");

	chk_r1_lt_live: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE2]
		(i_src_event[CEI_REF1_LT] && !mask_ff[CEI_REF1_LT]) |=> o_ref1_disq)
		else $error("unmasked long-term fault kept second input qualified");

	chk_r0_st_live: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE3]
		(i_src_event[CEI_REF0_ST] && !mask_ff[CEI_REF0_ST]) |=> o_ref0_disq)
		else $error("unmasked short-term fault kept first input qualified");

	chk_r0_mt_live: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE4]
		(i_src_event[CEI_REF0_MT] && !mask_ff[CEI_REF0_MT]) |=> o_ref0_disq)
		else $error("unmasked mid-term fault kept first input qualified");

	chk_r0_lt_live: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE5]
		(i_src_event[CEI_REF0_LT] && !mask_ff[CEI_REF0_LT]) |=> o_ref0_disq)
		else $error("unmasked long-term fault kept first input qualified");

	// disqualify is a level, not a latch: it must go once failures stop
	chk_disq1_drop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE1]
		(!i_src_event[CEI_REF1_MT] && !i_src_event[CEI_REF1_LT]) |=> !o_ref1_disq)
		else $error("second input stayed disqualified without failure");

	chk_disq0_drop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE4]
		(!i_src_event[CEI_REF0_ST] && !i_src_event[CEI_REF0_MT] && !i_src_event[CEI_REF0_LT])
		|=> !o_ref0_disq)
		else $error("first input stayed disqualified without failure");

	// every real source latches whatever its mask says
	for (genvar k = 0; k < CEI_NSRC; k++)
	begin : g_src
		if (k != CEI_RSVD)
		begin : g_live
			chk_src_latch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE22]
				i_src_event[k] |=> status_ff[k])
				else $error("event did not latch its status flag");
		end
	end

	chk_set_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE22]
		(clr_bits[CEI_RF_UNLOCK] && i_src_event[CEI_RF_UNLOCK]) |=> status_ff[CEI_RF_UNLOCK])
		else $error("clear beat a same-cycle unlock event");

	chk_rsvd_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE23]
		!pend_bits[CEI_RSVD] && !status_ff[CEI_RSVD])
		else $error("reserved position took part in interrupts");

	chk_mask_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE6]
		!wr_mask |=> (mask_ff == $past(mask_ff)))
		else $error("mask changed without a write");

	chk_mask_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE6]
		(wr_mask && i_wb_sel == {CEI_SEL_W{1'b1}}) |=> (mask_ff == $past(i_wb_dat[CEI_NSRC-1:0])))
		else $error("full mask write did not land");

	// bus answer: one ack per request, data only while ack stands
	chk_ack_follow: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE21]
		(i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
		else $error("request not answered in one cycle");

	chk_ack_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE21]
		o_wb_ack |=> !o_wb_ack)
		else $error("ack stood longer than one cycle");

	chk_rdat_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE21]
		!o_wb_ack |-> (o_wb_dat == CEI_RD_ZERO))
		else $error("read data shown outside ack");

	chk_status_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE22]
		(bus_hit && !i_wb_we && i_wb_adr == CEI_ADR_STATUS)
		|=> (o_wb_dat[CEI_NSRC-1:0] == $past(status_ff)))
		else $error("status read returned wrong flags");

	chk_pend_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE23]
		(bus_hit && !i_wb_we && i_wb_adr == CEI_ADR_PEND)
		|=> (o_wb_dat[CEI_NSRC-1:0] == ($past(status_ff) & ~$past(mask_ff) & CEI_VALID_BITS)))
		else $error("pending read returned wrong flags");

endmodule : cei_irq_mask

// ==== bench/cei_irq_mask_tb.sv ====
// self-checking bench for the clock event interrupt mask block
`timescale 1ns/1ps

module cei_irq_mask_tb;
	import cei_pkg::*;

	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [CEI_ADR_W-1:0] adr = '0;
	logic [CEI_SEL_W-1:0] sel = '0;
	logic [CEI_DAT_W-1:0] wdat = '0;
	logic [CEI_DAT_W-1:0] o_wb_dat;
	logic o_wb_ack;
	logic [CEI_NSRC-1:0] src = '0;
	logic o_irq;
	logic o_ref0_disq;
	logic o_ref1_disq;
	int num_errors = 0;
	int total_checks = 0;
	logic [31:0] q;

	cei_irq_mask DUT (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_wb_cyc(cyc),
		.i_wb_stb(stb),
		.i_wb_we(we),
		.i_wb_adr(adr),
		.i_wb_sel(sel),
		.i_wb_dat(wdat),
		.o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack),
		.i_src_event(src),
		.o_irq(o_irq),
		.o_ref0_disq(o_ref0_disq),
		.o_ref1_disq(o_ref1_disq)
	);

	always #2.5 i_core_clk = ~i_core_clk;

	task automatic conclude;
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one classic cycle; ack and read data are taken at the same edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge i_core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do
		begin
			@(posedge i_core_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		r = o_wb_dat;
		if (n >= 20)
			chk("ack", 32'h0, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, 4'hf, d, r);
		#1;
	endtask : wr

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 4'h0, 32'h0, r);
		chk(nm, r, exp);
		#1;
	endtask : rd

	// hold a failure level three cycles, then drop it; disqualify must follow
	task automatic ev_check(input int k, input logic ei, input logic e0, input logic e1);
		@(posedge i_core_clk);
		src <= 19'h1 << k;
		@(posedge i_core_clk);
		@(posedge i_core_clk);
		#1;
		chk("irq", o_irq, ei);
		chk("ref0_disq", o_ref0_disq, e0);
		chk("ref1_disq", o_ref1_disq, e1);
		@(posedge i_core_clk);
		src <= '0;
		@(posedge i_core_clk);
		#1;
		chk("ref0_disq_gone", o_ref0_disq, 1'b0);
		chk("ref1_disq_gone", o_ref1_disq, 1'b0);
	endtask : ev_check

	initial
	begin
		#50000;
		num_errors++;
		conclude();
	end

	initial
	begin
		logic [31:0] b;
		repeat (8) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		chk("irq_rst", o_irq, 1'b0);
		rd("mask_rst", CEI_ADR_MASK, {13'h0, CEI_MASK_RST});
		rd("status_rst", CEI_ADR_STATUS, {13'h0, CEI_STATUS_RST});
		rd("qual_rst", CEI_ADR_QUAL, 32'h0);
		// reserved bit stays zero in every mask write
		wr(CEI_ADR_MASK, {13'h0, CEI_VALID_BITS});
		rd("mask_rw", CEI_ADR_MASK, {13'h0, CEI_VALID_BITS});
		wr(CEI_ADR_MASK, 32'h0);
		for (int k = 0; k < CEI_NSRC; k++)
		begin
			if (k == CEI_RSVD)
				continue;
			b = 32'h1 << k;
			wr(CEI_ADR_MASK, b);
			ev_check(k, 1'b0, 1'b0, 1'b0);
			rd("status_set", CEI_ADR_STATUS, b);
			rd("pend_masked", CEI_ADR_PEND, 32'h0);
			chk("irq_masked", o_irq, 1'b0);
			wr(CEI_ADR_MASK, 32'h0);
			chk("irq_unmask", o_irq, 1'b1);
			ev_check(k, 1'b1, CEI_REF0_BITS[k], CEI_REF1_BITS[k]);
			rd("pend", CEI_ADR_PEND, b);
			wr(CEI_ADR_STATUS, b);
			chk("irq_clear", o_irq, 1'b0);
			rd("status_clr", CEI_ADR_STATUS, 32'h0);
		end
		// two flags pending; a zero write leaves a flag, the last clear drops irq
		@(posedge i_core_clk);
		src <= 19'h18000;
		@(posedge i_core_clk);
		src <= '0;
		wr(CEI_ADR_STATUS, 32'h8000);
		rd("status_w0", CEI_ADR_STATUS, 32'h10000);
		chk("irq_one_left", o_irq, 1'b1);
		wr(CEI_ADR_PEND, 32'hffffffff);
		rd("pend_ro", CEI_ADR_PEND, 32'h10000);
		wr(CEI_ADR_STATUS, 32'h10000);
		chk("irq_none_left", o_irq, 1'b0);
		// unmapped place and a single byte lane
		wr(8'h10, 32'hffffffff);
		rd("unmapped", 8'h10, 32'h0);
		bus(1'b1, CEI_ADR_MASK, 4'h1, 32'hffffffff, q);
		rd("mask_lane", CEI_ADR_MASK, 32'hff);
		conclude();
	end

endmodule : cei_irq_mask_tb
